/* verilog/sscd_params.svh */
/*
 * Constants of the synchronous SRAM cycle decoder: widths, field positions, counts.
 * Assumes it is included by the package and by the design modules.
 */
`ifndef SSCD_PARAMS_SVH
`define SSCD_PARAMS_SVH

`define SSCD_LANES       4
`define SSCD_LANE_W      9
`define SSCD_PARITY_BIT  8
`define SSCD_ADDR_W      17
`define SSCD_BURST_W     2
`define SSCD_BUF_DEPTH   2
`define SSCD_CLK_NS      25
`define SSCD_PIPE_STAGES 2

`endif

/* verilog/sscd_pkg.sv */
/*
 * Types shared by the cycle decoder modules: pin group, pipeline command, state.
 * Assumes sscd_params.svh is on the include path.
 */
`include "sscd_params.svh"

package sscd_pkg;

	typedef enum logic {
		SSCD_ST_IDLE,
		SSCD_ST_BURST
	} sscd_state_t;

	// synchronous control pins of the host port
	typedef struct packed {
		logic                     advance_or_load;
		logic                     read_write_n;
		logic                     chip_en_n;
		logic                     chip_en2_n;
		logic                     chip_en2;
		logic [`SSCD_LANES-1:0]   byte_lane_write_en_n;
		logic [`SSCD_ADDR_W-1:0]  addr;
	} sscd_ctrl_t;

	// one beat travelling down the pipeline
	typedef struct packed {
		logic                     valid;
		logic                     write;
		logic [`SSCD_ADDR_W-1:0]  addr;
		logic [`SSCD_LANES-1:0]   be_n;
	} sscd_cmd_t;

endpackage

/* verilog/sscd_burst_seq.sv */
/*
 * Burst offset sequencer: start offset and beat number in, word offset out.
 * Assumes the mode input is held constant while bursts run.
 */
`timescale 1ns/10ps
`include "sscd_params.svh"

module sscd_burst_seq (
	// burst position
	input  wire logic [`SSCD_BURST_W-1:0] start_off,
	input  wire logic [`SSCD_BURST_W-1:0] beat,
	// order: 1 interleaved, 0 linear
	input  wire logic                     interleave,
	// resulting word offset
	output logic      [`SSCD_BURST_W-1:0] off
);

	always_comb begin
		if (interleave) begin
			off = start_off ^ beat;
		end else begin
			off = start_off + beat;
		end
	end

endmodule

/* verilog/sscd_buf2.sv */
/*
 * Small ready/valid buffer, two entries by default, holding read data.
 * Assumes the source stalls while in_ready is low.
 */
`timescale 1ns/10ps
`include "sscd_params.svh"

module sscd_buf2 #(
	parameter int W     = 36,
	parameter int DEPTH = `SSCD_BUF_DEPTH
) (
	// clock and reset
	input  wire logic         sys_clk,
	input  wire logic         arst_n,
	// filling side
	input  wire logic         in_valid,
	output logic              in_ready,
	input  wire logic [W-1:0] in_data,
	// draining side
	output logic              out_valid,
	input  wire logic         out_ready,
	output logic      [W-1:0] out_data
);

	localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
	localparam int CW = $clog2(DEPTH + 1);

	logic [W-1:0]  store_r [DEPTH];
	logic [PW-1:0] wp_r;
	logic [PW-1:0] wp_nxt;
	logic [PW-1:0] rp_r;
	logic [PW-1:0] rp_nxt;
	logic [CW-1:0] cnt_r;
	logic [CW-1:0] cnt_nxt;
	logic          push;
	logic          pop;

	function automatic logic [PW-1:0] bump(input logic [PW-1:0] p);
		bump = (p == PW'(DEPTH - 1)) ? '0 : p + 1'b1;
	endfunction

	assign in_ready  = (cnt_r != CW'(DEPTH));
	assign out_valid = (cnt_r != '0);
	assign out_data  = store_r[rp_r];
	assign push      = in_valid && in_ready;
	assign pop       = out_valid && out_ready;

	always_comb begin
		wp_nxt  = push ? bump(wp_r) : wp_r;
		rp_nxt  = pop ? bump(rp_r) : rp_r;
		cnt_nxt = cnt_r;
		if (push && !pop) begin
			cnt_nxt = cnt_r + 1'b1;
		end else if (pop && !push) begin
			cnt_nxt = cnt_r - 1'b1;
		end
	end

	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			wp_r  <= '0;
			rp_r  <= '0;
			cnt_r <= '0;
		end else begin
			wp_r  <= wp_nxt;
			rp_r  <= rp_nxt;
			cnt_r <= cnt_nxt;
		end
	end

	// storage carries no reset
	always_ff @(posedge sys_clk) begin
		if (push) begin
			store_r[wp_r] <= in_data;
		end
	end

endmodule

/* verilog/sscd_top.sv */
/*
 * Pipelined no-turnaround synchronous SRAM: cycle decode, burst counter,
 * byte-lane masking, memory array and buffered read data.
 * Assumes the controller drives pins synchronously to sys_clk, presents
 * write data two active edges after its address, and keeps the burst
 * order pin static (pulled high on the board when left open).
 */
`timescale 1ns/10ps
`include "sscd_params.svh"

module sscd_top #(
	parameter bit PARITY_EN = 1'b1,
	parameter int MEM_AW    = `SSCD_ADDR_W
) (
	// clock and reset
	input  wire logic                                   sys_clk,
	input  wire logic                                   arst_n,
	// synchronous control and asynchronous output enable
	input  wire sscd_pkg::sscd_ctrl_t                   ctrl,
	input  wire logic                                   clk_en_n,
	input  wire logic                                   burst_order_select_alt,
	input  wire logic                                   output_en_n,
	// data pins, split into input, output and enable
	input  wire logic [`SSCD_LANES*`SSCD_LANE_W-1:0]    data_in,
	output logic      [`SSCD_LANES*`SSCD_LANE_W-1:0]    data_out,
	output logic                                        data_oe_n,
	// read data handshake
	output logic                                        rd_valid,
	input  wire logic                                   rd_ready,
	// status
	output logic                                        busy,
	output logic                                        cycle_is_write,
	output logic      [`SSCD_BURST_W-1:0]               burst_beat
);

	localparam int LANES = `SSCD_LANES;
	localparam int LW    = `SSCD_LANE_W;
	localparam int DW    = LANES * LW;
	localparam int AW    = `SSCD_ADDR_W;
	localparam int BW    = `SSCD_BURST_W;

	// lanes selected by active-low enables, ninth bits dropped when narrow
	function automatic logic [DW-1:0] lane_mask(
		input logic [LANES-1:0] be_n,
		input logic             all_lanes
	);
		logic [DW-1:0] m;
		m = '0;
		for (int i = 0; i < LANES; i++) begin
			if (all_lanes || !be_n[i]) begin
				m[i*LW +: LW] = {LW{1'b1}};
			end
			if (!PARITY_EN) begin
				m[i*LW + `SSCD_PARITY_BIT] = 1'b0;
			end
		end
		lane_mask = m;
	endfunction

	// one pipeline beat; loads and advances both build it
	function automatic sscd_pkg::sscd_cmd_t make_cmd(
		input logic             write,
		input logic [AW-1:0]    addr,
		input logic [LANES-1:0] be_n
	);
		sscd_pkg::sscd_cmd_t c;
		c.valid  = 1'b1;
		c.write  = write;
		c.addr   = addr;
		c.be_n   = be_n;
		make_cmd = c;
	endfunction

	// burst and pipeline state
	sscd_pkg::sscd_state_t state_r;
	sscd_pkg::sscd_state_t state_nxt;
	logic [AW-BW-1:0]      base_r;
	logic [AW-BW-1:0]      base_nxt;
	logic [BW-1:0]         start_r;
	logic [BW-1:0]         start_nxt;
	logic [BW-1:0]         beat_r;
	logic [BW-1:0]         beat_nxt;
	logic                  dir_r;
	logic                  dir_nxt;
	sscd_pkg::sscd_cmd_t   s1_r;
	sscd_pkg::sscd_cmd_t   s1_nxt;
	sscd_pkg::sscd_cmd_t   s2_r;
	sscd_pkg::sscd_cmd_t   s2_nxt;

	// memory and read path
	logic [DW-1:0]         mem_r [2**MEM_AW];
	logic [BW-1:0]         step_beat;
	logic [BW-1:0]         step_off;
	logic                  selected;
	logic                  go;
	logic                  stall;
	logic                  rd_push;
	logic                  buf_in_ready;
	logic [DW-1:0]         rd_word;
	logic [DW-1:0]         wr_mask;
	logic [MEM_AW-1:0]     s2_index;
	logic                  load_take;
	logic                  step_take;
	logic                  mem_we;
	logic                  buf_out_ready;
	logic [DW-1:0]         mem_wdata;

	assign selected  = !ctrl.chip_en_n && !ctrl.chip_en2_n && ctrl.chip_en2;
	assign step_beat = beat_r + 1'b1;
	assign s2_index  = s2_r.addr[MEM_AW-1:0];

	// next beat offset of the running burst
	sscd_burst_seq u_seq (
		.start_off  (start_r),
		.beat       (step_beat),
		.interleave (burst_order_select_alt),
		.off        (step_off)
	);

	// a read word reaching a full read buffer holds the whole pipeline, like a stretched cycle
	assign rd_push = !clk_en_n && s2_r.valid && !s2_r.write;
	assign stall   = rd_push && !buf_in_ready;
	assign go      = !clk_en_n && !stall;

	// a disabled clock also holds the read buffer
	assign buf_out_ready = rd_ready && !clk_en_n;

	// load on low, advance on high
	assign load_take = go && !ctrl.advance_or_load && selected;
	assign step_take = go && ctrl.advance_or_load && (state_r == sscd_pkg::SSCD_ST_BURST);

	// burst counter group: state, base address, start offset, beat, direction
	always_comb begin
		state_nxt = state_r;
		base_nxt  = base_r;
		start_nxt = start_r;
		beat_nxt  = beat_r;
		dir_nxt   = dir_r;
		if (load_take) begin
			state_nxt = sscd_pkg::SSCD_ST_BURST;
			base_nxt  = ctrl.addr[AW-1:BW];
			start_nxt = ctrl.addr[BW-1:0];
			beat_nxt  = '0;
			dir_nxt   = !ctrl.read_write_n;
		end else if (go && !ctrl.advance_or_load) begin
			// deselect ends any burst
			state_nxt = sscd_pkg::SSCD_ST_IDLE;
		end else if (step_take) begin
			beat_nxt  = step_beat;
		end
	end

	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			state_r <= sscd_pkg::SSCD_ST_IDLE;
			base_r  <= '0;
			start_r <= '0;
			beat_r  <= '0;
			dir_r   <= 1'b0;
		end else begin
			state_r <= state_nxt;
			base_r  <= base_nxt;
			start_r <= start_nxt;
			beat_r  <= beat_nxt;
			dir_r   <= dir_nxt;
		end
	end

	// pipeline group: two stages between the address edge and the data edge
	always_comb begin
		s1_nxt = s1_r;
		s2_nxt = s2_r;
		if (go) begin
			s1_nxt = '0;
			s2_nxt = s1_r;
			if (load_take) begin
				s1_nxt = make_cmd(!ctrl.read_write_n, ctrl.addr,
					ctrl.byte_lane_write_en_n);
			end else if (step_take) begin
				s1_nxt = make_cmd(dir_r, {base_r, step_off},
					ctrl.byte_lane_write_en_n);
			end
		end
	end

	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			s1_r <= '0;
			s2_r <= '0;
		end else begin
			s1_r <= s1_nxt;
			s2_r <= s2_nxt;
		end
	end

	assign wr_mask = lane_mask(s2_r.be_n, 1'b0);

	// array is not reset; contents are undefined until written
	always_comb begin
		mem_we    = go && s2_r.valid && s2_r.write;
		mem_wdata = (mem_r[s2_index] & ~wr_mask) | (data_in & wr_mask);
	end

	always_ff @(posedge sys_clk) begin
		if (mem_we) begin
			mem_r[s2_index] <= mem_wdata;
		end
	end

	assign rd_word = mem_r[s2_index] & lane_mask('0, 1'b1);

	sscd_buf2 #(
		.W     (DW),
		.DEPTH (`SSCD_BUF_DEPTH)
	) u_rdbuf (
		.sys_clk   (sys_clk),
		.arst_n    (arst_n),
		.in_valid  (rd_push),
		.in_ready  (buf_in_ready),
		.in_data   (rd_word),
		.out_valid (rd_valid),
		.out_ready (buf_out_ready),
		.out_data  (data_out)
	);

	// pins driven only with data waiting and output enabled
	assign data_oe_n      = output_en_n || !rd_valid;
	assign busy           = (state_r == sscd_pkg::SSCD_ST_BURST) || s1_r.valid || s2_r.valid;
	assign cycle_is_write = dir_r;
	assign burst_beat     = beat_r;

endmodule

/* sim/sscd_top_props.sv */
/* Port checker for sscd_top: decode, freeze, read timing, buffer hold.
   Assumes it is bound onto sscd_top and the package is compiled first. */
`timescale 1ns/10ps
module sscd_top_props (
	// clock and reset
	input wire logic	sys_clk,
	input wire logic	arst_n,
	// watched ports
	input wire sscd_pkg::sscd_ctrl_t	ctrl,
	input wire logic	clk_en_n,
	input wire logic	rd_valid,
	input wire logic	rd_ready,
	input wire logic [35:0]	data_out,
	input wire logic	busy,
	input wire logic	cycle_is_write,
	input wire logic [1:0]	burst_beat
);
	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (!arst_n);
	// selected load on a taken edge; empty buffer rules out a stall
	wire ld = !ctrl.advance_or_load && !ctrl.chip_en_n && !ctrl.chip_en2_n && ctrl.chip_en2
		&& !clk_en_n && !rd_valid;
	sequence s_rd_load;
		ld && ctrl.read_write_n;
	endsequence
	sequence s_run2;
		(!clk_en_n && rd_ready)[*2];
	endsequence
	a_load_write: assert property (ld && !ctrl.read_write_n |=> cycle_is_write)
		else $error("write load not decoded");
	a_load_read: assert property (s_rd_load |=> !cycle_is_write)
		else $error("read load not decoded");
	a_beat_seed: assert property (ld |=> burst_beat == 2'h0)
		else $error("beat not cleared on load");
	a_dir_hold: assert property (ctrl.advance_or_load |=> $stable(cycle_is_write))
		else $error("direction changed on advance");
	a_freeze_all: assert property (
		clk_en_n |=> $stable(burst_beat) && $stable(cycle_is_write) && $stable(rd_valid))
		else $error("state moved while clock disabled");
	a_read_latency: assert property (s_rd_load ##1 s_run2 |=> rd_valid)
		else $error("read word late");
	a_adv_idle: assert property (!busy && ctrl.advance_or_load |=> !busy)
		else $error("advance started work when idle");
	a_read_hold: assert property (rd_valid && !rd_ready |=> rd_valid && $stable(data_out))
		else $error("buffered word lost");
endmodule

bind sscd_top sscd_top_props u_props (.sys_clk(sys_clk), .arst_n(arst_n), .ctrl(ctrl),
	.clk_en_n(clk_en_n), .rd_valid(rd_valid), .rd_ready(rd_ready), .data_out(data_out),
	.busy(busy), .cycle_is_write(cycle_is_write), .burst_beat(burst_beat));

/* sim/sscd_host_model.sv */
/* Controller model: drives control, clock enable, burst order and write data.
   Assumes each call starts just after a rising edge, one beat per call. */
`timescale 1ns/10ps
module sscd_host_model (
	// clock
	input wire logic	sys_clk,
	// pins toward the device
	output sscd_pkg::sscd_ctrl_t	ctrl,
	output logic	clk_en_n,
	output logic	burst_order_select_alt,
	output logic [35:0]	data_in
);
	logic	wr_now;
	logic [1:0]	wq;
	logic [35:0]	dq [2];
	initial begin
		ctrl = '0;
		ctrl.chip_en_n = 1'b1;
		clk_en_n = 1'b0;
		burst_order_select_alt = 1'b1;
		data_in = '0;
		wr_now = 1'b0;
		wq = 2'h0;
	end
	task cyc(input logic adv, input logic rw, input logic sel, input logic [3:0] be,
		input logic [16:0] a, input logic [35:0] d);
		ctrl <= '{adv, rw, !sel, !sel, sel, be, a};
		wr_now = adv ? wr_now : sel && !rw;
		// idle data lines toggle so stale words never match
		data_in <= wq[1] ? dq[1] : ~data_in;
		wq = {wq[0], wr_now};
		dq[1] = dq[0];
		dq[0] = d;
		@(posedge sys_clk);
	endtask
	task hold();
		clk_en_n <= 1'b1;
		@(posedge sys_clk);
		clk_en_n <= 1'b0;
	endtask
	task mode(input logic m);
		burst_order_select_alt <= m;
	endtask
endmodule

/* sim/test_sync_sram_cycle_decode.sv */
/* Self-checking bench for sscd_top driven through the controller model.
   Assumes package, design, checker and model are compiled first. */
`timescale 1ns/10ps
module test_sync_sram_cycle_decode;
	logic	sys_clk = 1'b0;
	logic	arst_n = 1'b0;
	logic	rd_ready = 1'b1;
	logic	output_en_n = 1'b0;
	logic	clk_en_n;
	logic	order_sel;
	logic	data_oe_n;
	logic	rd_valid;
	logic [35:0]	data_in;
	logic [35:0]	data_out;
	logic [35:0]	mem_x [64];
	logic [35:0]	exp_q [$];
	logic [35:0]	got [$];
	logic [35:0]	got_nw [$];
	logic	nw_valid;
	logic [35:0]	nw_out;
	sscd_pkg::sscd_ctrl_t	ctrl;
	int	error_cnt = 0;
	int	num_checks = 0;

	always #12.5 sys_clk = ~sys_clk;

	sscd_host_model ctl (.sys_clk(sys_clk), .ctrl(ctrl), .clk_en_n(clk_en_n),
		.burst_order_select_alt(order_sel), .data_in(data_in));
	sscd_top #(.MEM_AW(6)) DUT (.sys_clk(sys_clk), .arst_n(arst_n), .ctrl(ctrl),
		.clk_en_n(clk_en_n), .burst_order_select_alt(order_sel), .output_en_n(output_en_n),
		.data_in(data_in), .data_out(data_out), .data_oe_n(data_oe_n), .rd_valid(rd_valid),
		.rd_ready(rd_ready), .busy(), .cycle_is_write(), .burst_beat());
	// narrow variant runs in lockstep beside the wide one
	sscd_top #(.PARITY_EN(1'b0), .MEM_AW(6)) u_narrow (.sys_clk(sys_clk), .arst_n(arst_n),
		.ctrl(ctrl), .clk_en_n(clk_en_n), .burst_order_select_alt(order_sel),
		.output_en_n(output_en_n), .data_in(data_in), .data_out(nw_out), .data_oe_n(),
		.rd_valid(nw_valid), .rd_ready(rd_ready), .busy(), .cycle_is_write(), .burst_beat());

	// nothing pops while the clock is disabled
	always @(posedge sys_clk) begin
		if (rd_valid === 1'b1 && rd_ready === 1'b1 && clk_en_n === 1'b0)
			got.push_back(data_out);
		if (nw_valid === 1'b1 && rd_ready === 1'b1 && clk_en_n === 1'b0)
			got_nw.push_back(nw_out);
	end

	task wrap_up();
		if (error_cnt == 0 && num_checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	task chk(input string what, input logic [35:0] e, input logic [35:0] g);
		num_checks++;
		if (g !== e) begin
			error_cnt++;
			$display("MISMATCH %s expected %h seen %h", what, e, g);
		end
	endtask
	task idle(input int n, input logic adv);
		repeat (n) ctl.cyc(adv, 1'b1, 1'b0, 4'hf, '0, '0);
	endtask
	// four beats; advances carry the wrong direction and a junk address
	task automatic burst(input logic w, input logic [5:0] a, input logic [3:0] be,
		input logic [35:0] d, input int hold_at);
		logic [5:0]	wa;
		logic [35:0]	dd;
		for (int b = 0; b < 4; b++) begin
			wa = {a[5:2], order_sel ? a[1:0] ^ 2'(b) : a[1:0] + 2'(b)};
			dd = d + 36'(b);
			ctl.cyc(b != 0, (b == 0) ^ w, 1'b1, be, b ? ~17'(a) : 17'(a), dd);
			if (b == hold_at)
				ctl.hold();
			for (int i = 0; i < 4; i++)
				if (w && !be[i])
					mem_x[wa][9*i +: 9] = dd[9*i +: 9];
			if (!w)
				exp_q.push_back(mem_x[wa]);
		end
	endtask
	task drain();
		logic [35:0]	e;
		idle(6, 1'b0);
		idle(6, 1'b1);
		#1;
		chk("count", 36'(exp_q.size()), 36'(got.size()));
		chk("narrow count", 36'(exp_q.size()), 36'(got_nw.size()));
		while (exp_q.size() > 0 && got.size() > 0 && got_nw.size() > 0) begin
			e = exp_q.pop_front();
			chk("word", e, got.pop_front());
			chk("narrow word", e & 36'h7_fbfd_feff, got_nw.pop_front());
		end
		exp_q.delete();
		got.delete();
		got_nw.delete();
	endtask
	task t_linear();
		ctl.mode(1'b0);
		idle(1, 1'b0);
		burst(1'b1, 6'h03, 4'h0, 36'h1_0102_0304, -1);
		idle(3, 1'b0);
		burst(1'b0, 6'h01, 4'hf, '0, -1);
		drain();
	endtask
	task t_interleave();
		ctl.mode(1'b1);
		idle(1, 1'b0);
		burst(1'b1, 6'h06, 4'h0, 36'h9_2345_6781, 1);
		burst(1'b1, 6'h05, 4'ha, 36'hf_ffff_ffff, 2);
		idle(3, 1'b0);
		burst(1'b0, 6'h07, 4'hf, '0, 0);
		drain();
	endtask
	task t_stall();
		rd_ready <= 1'b0;
		burst(1'b0, 6'h04, 4'hf, '0, -1);
		idle(8, 1'b0);
		#1;
		chk("popped", '0, 36'(got.size()));
		chk("valid", 36'h1, 36'(rd_valid));
		chk("oe on", '0, 36'(data_oe_n));
		output_en_n <= 1'b1;
		idle(1, 1'b0);
		#1;
		chk("oe off", 36'h1, 36'(data_oe_n));
		output_en_n <= 1'b0;
		rd_ready <= 1'b1;
		drain();
	endtask
	task t_mix();
		burst(1'b0, 6'h01, 4'hf, '0, -1);
		burst(1'b1, 6'h0b, 4'h0, 36'h5_5aa5_0ff0, -1);
		burst(1'b0, 6'h04, 4'hf, '0, -1);
		idle(3, 1'b0);
		burst(1'b0, 6'h08, 4'hf, '0, -1);
		drain();
	endtask

	initial begin
		repeat (3) @(posedge sys_clk);
		arst_n <= 1'b1;
		t_linear();
		t_interleave();
		t_stall();
		t_mix();
		wrap_up();
	end
	initial begin
		#(2000 * 25);
		error_cnt++;
		wrap_up();
	end
endmodule
